// ==== hw/bpm_regs.vh ====
`ifndef BPM_REGS_VH
`define BPM_REGS_VH

// Software register offsets on the plain register port.
`define BPM_OFS_STATION 4'h0
`define BPM_OFS_INSTANCE 4'h4
`define BPM_OFS_STATUS 4'h8

// Status register fields.
`define BPM_ST_INVALID 0
`define BPM_ST_BUSY 1
`define BPM_ST_BAUD_LO 2
`define BPM_ST_BAUD_HI 3

// Reset values and station address limits.
`define BPM_STATION_RST 16'h270F
`define BPM_INSTANCE_RST 16'h0000
`define BPM_STATION_MAX 16'h007F

// Network value that stands for the drive's disabled code.
`define BPM_NET_DISABLED 16'h7FFF
`define BPM_DRV_DISABLED 16'h270F

// Point numbers.
`define BPM_PT_ENERGIZED 8'h1C
`define BPM_PT_OCCUPANCY 8'h1D
`define BPM_PT_RUN_HOURS 8'h1E
`define BPM_PT_LOAD 8'h1F
`define BPM_PT_ENERGY 8'h20
`define BPM_PT_SAVE_EFFECT 8'h21
`define BPM_PT_SAVED 8'h22
`define BPM_PT_SP_MON 8'h23
`define BPM_PT_MEAS 8'h24
`define BPM_PT_DEV 8'h25
`define BPM_PT_FAULT_RST 8'h26
`define BPM_PT_FWD 8'h27
`define BPM_PT_REV 8'h28
`define BPM_PT_CUR_SEL 8'h29
`define BPM_PT_LOW 8'h2A
`define BPM_PT_MID 8'h2B
`define BPM_PT_HIGH 8'h2C
`define BPM_PT_SECOND 8'h2D
`define BPM_PT_HALT 8'h2E
`define BPM_PT_MODE 8'h2F
`define BPM_PT_FREQ 8'h30
`define BPM_PT_ALARM 8'h31
`define BPM_PT_MIN_FREQ 8'h32
`define BPM_PT_ACCEL 8'h33
`define BPM_PT_DECEL 8'h34
`define BPM_PT_SKIP_LO 8'h35
`define BPM_PT_SKIP_HI 8'h36
`define BPM_PT_SP_CMD 8'h37
`define BPM_PT_OVERRIDE 8'h14
`define BPM_PT_ERROR 8'h63

// Drive holding registers.
`define BPM_MB_FAULT_RST 16'h0002
`define BPM_MB_TERMINALS 16'h0009
`define BPM_MB_MODE 16'h000A
`define BPM_MB_FREQ 16'h000E
`define BPM_MB_ENERGIZED 16'h00DC
`define BPM_MB_RUN_HOURS 16'h00DF
`define BPM_MB_LOAD 16'h00E0
`define BPM_MB_ENERGY 16'h00E1
`define BPM_MB_SAVE_EFFECT 16'h00FA
`define BPM_MB_SAVED 16'h00FB
`define BPM_MB_SP_MON 16'h00FC
`define BPM_MB_MEAS 16'h00FD
`define BPM_MB_DEV 16'h00FE
`define BPM_MB_ALARM 16'h01F5
`define BPM_MB_MIN_FREQ 16'h03EA
`define BPM_MB_ACCEL 16'h03EF
`define BPM_MB_DECEL 16'h03F0
`define BPM_MB_SKIP_LO 16'h0407
`define BPM_MB_SKIP_HI 16'h0408
`define BPM_MB_SP_CMD 16'h046D

// Terminal command bit positions in drive register 9.
`define BPM_BIT_FWD 4'h1
`define BPM_BIT_REV 4'h2
`define BPM_BIT_HIGH 4'h3
`define BPM_BIT_MID 4'h4
`define BPM_BIT_LOW 4'h5
`define BPM_BIT_SECOND 4'h7
`define BPM_BIT_CUR_SEL 4'h8
`define BPM_BIT_HALT 4'hA

// Clock and link rates.
`define BPM_CLK_HZ 50000000
`define BPM_OVERSAMPLE 16
`define BPM_BAUD_0 4800
`define BPM_BAUD_1 9600
`define BPM_BAUD_2 19200
`define BPM_BAUD_3 38400

`endif

// ==== hw/bpm_gateway.v ====
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "bpm_regs.vh"

module bpm_gateway
(
   input wire core_clk,
   input wire reset,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [15:0] reg_rdata,
   input wire [1:0] baud_switch,
   output reg bit_tick_x16,
   output wire invalid_address,
   output wire [15:0] instance_number,
   output wire [6:0] station_address,
   input wire pt_req_valid,
   output wire pt_req_ready,
   input wire pt_req_write,
   input wire [7:0] pt_req_num,
   input wire [15:0] pt_req_value,
   output reg pt_ack,
   output reg pt_err,
   output reg [15:0] pt_rdata,
   output reg mb_req,
   output reg mb_write,
   output reg [15:0] mb_addr,
   output reg [15:0] mb_wdata,
   input wire mb_done,
   input wire [15:0] mb_rdata
);

   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_DONE = 2'h2;

   // Oversample divisors; a longest period rounds down.
   localparam integer DIV_FULL_0 = `BPM_CLK_HZ / (`BPM_OVERSAMPLE * `BPM_BAUD_0);
   localparam integer DIV_FULL_1 = `BPM_CLK_HZ / (`BPM_OVERSAMPLE * `BPM_BAUD_1);
   localparam integer DIV_FULL_2 = `BPM_CLK_HZ / (`BPM_OVERSAMPLE * `BPM_BAUD_2);
   localparam integer DIV_FULL_3 = `BPM_CLK_HZ / (`BPM_OVERSAMPLE * `BPM_BAUD_3);

   // Twelve bits hold the slowest rate's divisor with room to spare.
   localparam [11:0] DIV_0 = DIV_FULL_0[11:0];
   localparam [11:0] DIV_1 = DIV_FULL_1[11:0];
   localparam [11:0] DIV_2 = DIV_FULL_2[11:0];
   localparam [11:0] DIV_3 = DIV_FULL_3[11:0];

   // Maps a point number to {mapped, translated, terminal, drive register}.
   function [18:0] point_map;
      input [7:0] num;
      begin
         case (num)
            `BPM_PT_ENERGIZED: point_map = {3'b100, `BPM_MB_ENERGIZED};
            `BPM_PT_RUN_HOURS: point_map = {3'b100, `BPM_MB_RUN_HOURS};
            `BPM_PT_LOAD: point_map = {3'b100, `BPM_MB_LOAD};
            `BPM_PT_ENERGY: point_map = {3'b100, `BPM_MB_ENERGY};
            `BPM_PT_SAVE_EFFECT: point_map = {3'b100, `BPM_MB_SAVE_EFFECT};
            `BPM_PT_SAVED: point_map = {3'b100, `BPM_MB_SAVED};
            `BPM_PT_SP_MON: point_map = {3'b100, `BPM_MB_SP_MON};
            `BPM_PT_MEAS: point_map = {3'b100, `BPM_MB_MEAS};
            `BPM_PT_DEV: point_map = {3'b100, `BPM_MB_DEV};
            `BPM_PT_FAULT_RST: point_map = {3'b100, `BPM_MB_FAULT_RST};
            `BPM_PT_FWD,
            `BPM_PT_REV,
            `BPM_PT_CUR_SEL,
            `BPM_PT_LOW,
            `BPM_PT_MID,
            `BPM_PT_HIGH,
            `BPM_PT_SECOND,
            `BPM_PT_HALT: point_map = {3'b101, `BPM_MB_TERMINALS};
            `BPM_PT_MODE: point_map = {3'b100, `BPM_MB_MODE};
            `BPM_PT_FREQ: point_map = {3'b100, `BPM_MB_FREQ};
            `BPM_PT_ALARM: point_map = {3'b100, `BPM_MB_ALARM};
            `BPM_PT_MIN_FREQ: point_map = {3'b100, `BPM_MB_MIN_FREQ};
            `BPM_PT_ACCEL: point_map = {3'b100, `BPM_MB_ACCEL};
            `BPM_PT_DECEL: point_map = {3'b100, `BPM_MB_DECEL};
            `BPM_PT_SKIP_LO: point_map = {3'b110, `BPM_MB_SKIP_LO};
            `BPM_PT_SKIP_HI: point_map = {3'b110, `BPM_MB_SKIP_HI};
            `BPM_PT_SP_CMD: point_map = {3'b110, `BPM_MB_SP_CMD};
            default: point_map = {3'b000, 16'h0000};
         endcase
      end
   endfunction

   // Bit of drive register 9 that a terminal point drives.
   function [3:0] term_bit;
      input [7:0] num;
      begin
         case (num)
            `BPM_PT_FWD: term_bit = `BPM_BIT_FWD;
            `BPM_PT_REV: term_bit = `BPM_BIT_REV;
            `BPM_PT_CUR_SEL: term_bit = `BPM_BIT_CUR_SEL;
            `BPM_PT_SECOND: term_bit = `BPM_BIT_SECOND;
            `BPM_PT_HALT: term_bit = `BPM_BIT_HALT;
            `BPM_PT_LOW: term_bit = `BPM_BIT_LOW;
            `BPM_PT_MID: term_bit = `BPM_BIT_MID;
            `BPM_PT_HIGH: term_bit = `BPM_BIT_HIGH;
            default: term_bit = 4'h0;
         endcase
      end
   endfunction

   // One-hot mask of the register 9 bit that a terminal point drives.
   function [15:0] term_mask;
      input [7:0] num;
      begin
         term_mask = 16'h0001 << term_bit(num);
      end
   endfunction

   // Points that exist only so that older controllers see a full point list.
   function is_dummy;
      input [7:0] num;
      begin
         is_dummy = (num == `BPM_PT_OCCUPANCY) || (num == `BPM_PT_OVERRIDE) || (num == `BPM_PT_ERROR);
      end
   endfunction

   reg [1:0] state_reg;
   reg [15:0] station_reg;
   reg [15:0] instance_reg;
   reg [15:0] term_word_reg;
   reg xlate_reg;
   reg term_reg;
   reg [3:0] bit_reg;
   reg [1:0] baud_meta_reg;
   reg [1:0] baud_sync_reg;
   reg [11:0] div_cnt_reg;
   reg [11:0] div_sel;
   reg [15:0] status_word;
   wire [18:0] map;
   wire accept;
   wire [15:0] drive_value;
   wire [15:0] term_next;

   assign pt_req_ready = (state_reg == ST_IDLE);
   assign accept = pt_req_valid && pt_req_ready;
   assign map = point_map(pt_req_num);
   assign invalid_address = (station_reg > `BPM_STATION_MAX);
   assign station_address = station_reg[6:0];
   assign instance_number = instance_reg;

   // Network 327.67 stands for the drive's disabled or analog-input code.
   assign drive_value = (map[17] && pt_req_value == `BPM_NET_DISABLED) ? `BPM_DRV_DISABLED
                        : pt_req_value;

   // Any nonzero value sets a terminal; the other bits keep their last command.
   assign term_next = (pt_req_value != 16'h0000) ? (term_word_reg | term_mask(pt_req_num))
                      : (term_word_reg & ~term_mask(pt_req_num));

   always @(posedge core_clk)
   begin
      if (reset)
      begin
         state_reg <= ST_IDLE;
         term_word_reg <= 16'h0000;
         xlate_reg <= 1'b0;
         term_reg <= 1'b0;
         bit_reg <= 4'h0;
         mb_req <= 1'b0;
         mb_write <= 1'b0;
         mb_addr <= 16'h0000;
         mb_wdata <= 16'h0000;
         pt_ack <= 1'b0;
         pt_err <= 1'b0;
         pt_rdata <= 16'h0000;
      end
      else
      begin
         mb_req <= 1'b0;
         pt_ack <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               if (accept)
               begin
                  pt_err <= 1'b0;
                  pt_rdata <= 16'h0000;
                  xlate_reg <= map[17];
                  term_reg <= map[16];
                  bit_reg <= term_bit(pt_req_num);
                  if (map[18])
                  begin
                     // The drive acts on terminal bits only under network run/stop control.
                     mb_req <= 1'b1;
                     mb_write <= pt_req_write;
                     mb_addr <= map[15:0];
                     if (map[16] && pt_req_write)
                     begin
                        mb_wdata <= term_next;
                        term_word_reg <= term_next;
                     end
                     else
                     begin
                        mb_wdata <= drive_value;
                     end
                     state_reg <= ST_WAIT;
                  end
                  else
                  begin
                     // Dummy points answer at once; anything else is refused.
                     pt_err <= ~is_dummy(pt_req_num);
                     state_reg <= ST_DONE;
                  end
               end
            end
            ST_WAIT:
            begin
               if (mb_done)
               begin
                  if (mb_write)
                  begin
                     pt_rdata <= mb_wdata;
                  end
                  else if (term_reg)
                  begin
                     pt_rdata <= {15'h0000, mb_rdata[bit_reg]};
                  end
                  else if (xlate_reg && mb_rdata == `BPM_DRV_DISABLED)
                  begin
                     pt_rdata <= `BPM_NET_DISABLED;
                  end
                  else
                  begin
                     pt_rdata <= mb_rdata;
                  end
                  state_reg <= ST_DONE;
               end
            end
            ST_DONE:
            begin
               pt_ack <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Register port; reads answer in the following cycle.
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         station_reg <= `BPM_STATION_RST;
         instance_reg <= `BPM_INSTANCE_RST;
         reg_rdata <= 16'h0000;
      end
      else
      begin
         if (reg_write && reg_addr == `BPM_OFS_STATION)
         begin
            station_reg <= reg_wdata;
         end
         if (reg_write && reg_addr == `BPM_OFS_INSTANCE)
         begin
            instance_reg <= reg_wdata;
         end
         reg_rdata <= 16'h0000;
         if (reg_read)
         begin
            case (reg_addr)
               `BPM_OFS_STATION: reg_rdata <= station_reg;
               `BPM_OFS_INSTANCE: reg_rdata <= instance_reg;
               `BPM_OFS_STATUS: reg_rdata <= status_word;
               default: reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // Status fields sit where the field macros place them, so software and logic agree.
   always @*
   begin
      status_word = 16'h0000;
      status_word[`BPM_ST_INVALID] = invalid_address;
      status_word[`BPM_ST_BUSY] = ~pt_req_ready;
      status_word[`BPM_ST_BAUD_HI:`BPM_ST_BAUD_LO] = baud_sync_reg;
   end

   // The switches are asynchronous, so they pass two flip-flops first.
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         baud_meta_reg <= 2'h0;
         baud_sync_reg <= 2'h0;
      end
      else
      begin
         baud_meta_reg <= baud_switch;
         baud_sync_reg <= baud_meta_reg;
      end
   end

   always @*
   begin
      case (baud_sync_reg)
         2'h0: div_sel = DIV_0;
         2'h1: div_sel = DIV_1;
         2'h2: div_sel = DIV_2;
         2'h3: div_sel = DIV_3;
         default: div_sel = DIV_1;
      endcase
   end

   // A switch change applies to the running count at once; a count already past the new limit wraps on the next cycle.
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         div_cnt_reg <= 12'h000;
         bit_tick_x16 <= 1'b0;
      end
      else if (div_cnt_reg >= div_sel - 12'h001)
      begin
         div_cnt_reg <= 12'h000;
         bit_tick_x16 <= 1'b1;
      end
      else
      begin
         div_cnt_reg <= div_cnt_reg + 12'h001;
         bit_tick_x16 <= 1'b0;
      end
   end

endmodule // bpm_gateway
`default_nettype wire

// ==== tb/bpm_gateway_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module bpm_gateway_sva
(
   input wire core_clk,
   input wire reset,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire invalid_address,
   input wire [6:0] station_address,
   input wire pt_req_valid,
   input wire pt_req_ready,
   input wire pt_req_write,
   input wire [7:0] pt_req_num,
   input wire [15:0] pt_req_value,
   input wire pt_ack,
   input wire pt_err,
   input wire mb_req,
   input wire mb_write,
   input wire [15:0] mb_addr,
   input wire [15:0] mb_wdata,
   input wire mb_done
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire acc = pt_req_valid && pt_req_ready;
   wire acc_wr = acc && pt_req_write;
   chk_mb_pulse: assert property (mb_req |=> !mb_req)
      else $error("drive request longer than one cycle");
   chk_ack_ready: assert property (pt_ack |-> pt_req_ready ##1 !pt_ack)
      else $error("answer not a pulse or not ready after it");
   chk_accept_busy: assert property (acc |=> !pt_req_ready)
      else $error("ready stayed high after accept");
   chk_done_ack: assert property (mb_done && !pt_req_ready |-> ##2 pt_ack)
      else $error("no answer two cycles after drive done");
   chk_term_reg: assert property (acc_wr && pt_req_num == 8'h27 |=> mb_req && mb_write && mb_addr == 16'h0009)
      else $error("forward run not sent to register 9");
   chk_freq_write: assert property (acc_wr && pt_req_num == 8'h30 |=>
      mb_req && mb_addr == 16'h000E && mb_wdata == $past(pt_req_value))
      else $error("frequency command not forwarded");
   chk_skip_xlate: assert property (acc_wr && pt_req_num == 8'h35 && pt_req_value == 16'h7FFF |=>
      mb_wdata == 16'h270F)
      else $error("disabled value not translated");
   chk_dummy_quiet: assert property (acc && pt_req_num == 8'h63 |=> !mb_req ##1 pt_ack && !pt_err)
      else $error("compatibility point touched the drive");
   chk_station_range: assert property (reg_write && reg_addr == 4'h0 |=>
      invalid_address == ($past(reg_wdata) > 16'h007F))
      else $error("invalid address flag wrong");
   chk_station_low: assert property (reg_write && reg_addr == 4'h0 |=>
      station_address == $past(reg_wdata[6:0]))
      else $error("station address output wrong");
endmodule // bpm_gateway_sva
bind bpm_gateway bpm_gateway_sva chk_i (
   .core_clk(core_clk),
   .reset(reset),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_write(reg_write),
   .invalid_address(invalid_address),
   .station_address(station_address),
   .pt_req_valid(pt_req_valid),
   .pt_req_ready(pt_req_ready),
   .pt_req_write(pt_req_write),
   .pt_req_num(pt_req_num),
   .pt_req_value(pt_req_value),
   .pt_ack(pt_ack),
   .pt_err(pt_err),
   .mb_req(mb_req),
   .mb_write(mb_write),
   .mb_addr(mb_addr),
   .mb_wdata(mb_wdata),
   .mb_done(mb_done)
);
`default_nettype wire

// ==== tb/bpm_drive_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module bpm_drive_model
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic mb_req,
   input wire logic mb_write,
   input wire logic [15:0] mb_addr,
   input wire logic [15:0] mb_wdata,
   output logic mb_done,
   output logic [15:0] mb_rdata
);
   logic [15:0] mem [logic [15:0]];
   logic [15:0] val;
   int cnt = -1;
   int d;
   int seed = 6;
   // Skip limits and loop setpoint leave the factory disabled.
   initial
   begin
      mem[16'h0407] = 16'h270F;
      mem[16'h0408] = 16'h270F;
      mem[16'h046D] = 16'h270F;
   end
   // Idle read data toggles so a stale sample can never look right.
   always @(posedge core_clk)
   begin
      mb_done <= 1'b0;
      mb_rdata <= ~mb_rdata;
      if (reset)
      begin
         cnt <= -1;
         mb_rdata <= 16'h0000;
      end
      else if (mb_req)
      begin
         // Always in network control, so terminal words are stored as sent.
         if (mb_write)
            mem[mb_addr] = (mb_addr == 16'h01F5) ? 16'h0000 : mb_wdata;
         val = mem.exists(mb_addr) ? mem[mb_addr] : mb_addr ^ 16'h5A00;
         d = $random(seed) & 3;
         cnt <= d - 1;
         if (d == 0)
         begin
            mb_done <= 1'b1;
            mb_rdata <= val;
         end
      end
      else if (cnt == 0)
      begin
         mb_done <= 1'b1;
         mb_rdata <= val;
         cnt <= -1;
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
endmodule // bpm_drive_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [1:0] baud_switch = 2'h0;
   logic pt_req_valid = 1'b0;
   logic pt_req_write = 1'b0;
   logic [7:0] pt_req_num = 8'h00;
   logic [15:0] pt_req_value = 16'h0000;
   wire [15:0] reg_rdata, instance_number, pt_rdata, mb_addr, mb_wdata, mb_rdata;
   wire bit_tick_x16, invalid_address, pt_req_ready, pt_ack, pt_err, mb_req, mb_write, mb_done;
   wire [6:0] station_address;
   int error_cnt = 0;
   int total_checks = 0;
   int seed = 6;
   int n;
   logic [15:0] v, sh;
   logic [15:0] rq [$];
   logic [16:0] pq [$];
   logic [32:0] mq [$];
   logic rd_seen = 1'b0;
   logic [7:0] ro_pt [9] = '{8'h1C, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
   logic [15:0] ro_mb [9] = '{16'h00DC, 16'h00DF, 16'h00E0, 16'h00E1, 16'h00FA, 16'h00FB, 16'h00FC,
      16'h00FD, 16'h00FE};
   logic [7:0] rw_pt [7] = '{8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h26};
   logic [15:0] rw_mb [7] = '{16'h000A, 16'h000E, 16'h01F5, 16'h03EA, 16'h03EF, 16'h03F0, 16'h0002};
   logic [7:0] sk_pt [3] = '{8'h35, 8'h36, 8'h37};
   logic [15:0] sk_mb [3] = '{16'h0407, 16'h0408, 16'h046D};
   logic [7:0] tm_pt [8] = '{8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E};
   int tm_bit [8] = '{1, 2, 8, 5, 4, 3, 7, 10};
   logic [7:0] dm_pt [5] = '{8'h14, 8'h1D, 8'h63, 8'h05, 8'h38};
   logic [15:0] st_val [4] = '{16'h007F, 16'h0080, 16'h0000, 16'h270F};
   always #10 core_clk = ~core_clk;
   bpm_gateway dut (
      .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .baud_switch(baud_switch),
      .bit_tick_x16(bit_tick_x16), .invalid_address(invalid_address), .instance_number(instance_number),
      .station_address(station_address), .pt_req_valid(pt_req_valid), .pt_req_ready(pt_req_ready),
      .pt_req_write(pt_req_write), .pt_req_num(pt_req_num), .pt_req_value(pt_req_value),
      .pt_ack(pt_ack), .pt_err(pt_err), .pt_rdata(pt_rdata), .mb_req(mb_req), .mb_write(mb_write),
      .mb_addr(mb_addr), .mb_wdata(mb_wdata), .mb_done(mb_done), .mb_rdata(mb_rdata)
   );
   bpm_drive_model drv (
      .core_clk(core_clk), .reset(reset), .mb_req(mb_req), .mb_write(mb_write), .mb_addr(mb_addr),
      .mb_wdata(mb_wdata), .mb_done(mb_done), .mb_rdata(mb_rdata)
   );
   function automatic logic [15:0] rnd();
      return 16'($random(seed));
   endfunction
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_write <= wr;
      reg_read <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      if (!wr)
         rq.push_back(d);
      @(posedge core_clk);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
   endtask
   // A read sends a zero data word in the expectation since the design still loads the request value onto mb_wdata.
   task automatic pt(input logic w, input logic [7:0] num, input logic [15:0] val, input logic mbx,
      input logic [15:0] ma, input logic [15:0] md, input logic [16:0] r);
      if (mbx)
         mq.push_back({w, ma, w ? md : 16'h0000});
      pq.push_back(r);
      @(posedge core_clk);
      pt_req_valid <= 1'b1;
      pt_req_write <= w;
      pt_req_num <= num;
      pt_req_value <= val;
      @(negedge core_clk);
      for (int i = 0; i < 200 && !pt_req_ready; i++)
         @(negedge core_clk);
      @(posedge core_clk);
      pt_req_valid <= 1'b0;
      pt_req_value <= rnd();
   endtask
   task automatic tick_gap(output int cnt);
      cnt = 0;
      do
      begin
         @(posedge core_clk);
         cnt++;
      end
      while (!bit_tick_x16 && cnt < 2000);
   endtask
   always @(posedge core_clk)
   begin
      rd_seen <= reg_read;
      if (rd_seen)
         check(reg_rdata, rq.pop_front());
      else if (!reset)
         check(reg_rdata, 16'h0000);
      if (mb_req)
         check({mb_write, mb_addr, mb_write ? mb_wdata : 16'h0000}, mq.pop_front());
      if (pt_ack)
         check({pt_err, pt_rdata}, pq.pop_front());
   end
   initial
   begin
      #(20 * 40000);
      error_cnt++;
      wrap_up;
   end
   initial
   begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      @(negedge core_clk);
      check(invalid_address, 1'b1);
      check(station_address, 7'h0F);
      reg_acc(1'b0, 4'h0, 16'h270F);
      reg_acc(1'b0, 4'hC, 16'h0000);
      v = rnd();
      reg_acc(1'b1, 4'h4, v);
      reg_acc(1'b0, 4'h4, v);
      check(instance_number, v);
      foreach (st_val[i])
      begin
         reg_acc(1'b1, 4'h0, st_val[i]);
         @(negedge core_clk);
         check(invalid_address, st_val[i] > 16'h007F);
         check(station_address, st_val[i][6:0]);
         reg_acc(1'b0, 4'h0, st_val[i]);
      end
      for (int b = 0; b < 4; b++)
      begin
         baud_switch <= b[1:0];
         repeat (3) tick_gap(n);
         check(n, 50000000 / (16 * (4800 << b)));
      end
      reg_acc(1'b0, 4'h8, 16'h000D);
      foreach (ro_pt[i])
         pt(1'b0, ro_pt[i], rnd(), 1'b1, ro_mb[i], 16'h0000, {1'b0, ro_mb[i] ^ 16'h5A00});
      foreach (rw_pt[i])
      begin
         v = rnd();
         pt(1'b1, rw_pt[i], v, 1'b1, rw_mb[i], v, {1'b0, v});
         if (i < 6)
            pt(1'b0, rw_pt[i], v, 1'b1, rw_mb[i], 16'h0000, {1'b0, i == 2 ? 16'h0000 : v});
      end
      foreach (sk_pt[i])
      begin
         // Kept below the drive's disabled code so that a read-back is never translated.
         v = rnd() & 16'h1FFF;
         pt(1'b0, sk_pt[i], v, 1'b1, sk_mb[i], 16'h0000, 17'h0_7FFF);
         pt(1'b1, sk_pt[i], v, 1'b1, sk_mb[i], v, {1'b0, v});
         pt(1'b0, sk_pt[i], v, 1'b1, sk_mb[i], 16'h0000, {1'b0, v});
         pt(1'b1, sk_pt[i], 16'h7FFF, 1'b1, sk_mb[i], 16'h270F, 17'h0_270F);
      end
      sh = 16'h0000;
      foreach (tm_pt[i])
      begin
         sh[tm_bit[i]] = 1'b1;
         pt(1'b1, tm_pt[i], rnd() | 16'h0100, 1'b1, 16'h0009, sh, {1'b0, sh});
         pt(1'b0, tm_pt[i], 16'h0000, 1'b1, 16'h0009, 16'h0000, 17'h0_0001);
      end
      foreach (tm_pt[i])
      begin
         sh[tm_bit[i]] = 1'b0;
         pt(1'b1, tm_pt[i], 16'h0000, 1'b1, 16'h0009, sh, {1'b0, sh});
      end
      foreach (dm_pt[i])
         for (int w = 0; w < 2; w++)
            pt(w[0], dm_pt[i], rnd(), 1'b0, 16'h0000, 16'h0000, {i > 2, 16'h0000});
      repeat (20) @(posedge core_clk);
      check(pq.size() + mq.size() + rq.size(), 0);
      wrap_up;
   end
endmodule // tb_top
`default_nettype wire
